// >>> src/ssq_pkg.sv
// Purpose: shared constants and types of the sensor sampling sequencer
// Assumes: 40 MHz core clock, three converter channels
// Notes: delay choices are selected by the frequency code of the config
package ssq_pkg;

   // ----------------------------------------------------------------------
   // channels and widths
   // ----------------------------------------------------------------------
   localparam int SSQ_NUM_SENS = 3;
   localparam int SSQ_CHAN_W = 2;
   localparam int SSQ_DATA_W = 16;
   localparam int SSQ_PASS_W = 8;
   localparam int SSQ_FREQ_W = 2;
   localparam int SSQ_MS_W = 16;

   // channel order inside a pass: reference, thermistor, light
   localparam logic [SSQ_CHAN_W-1:0] SSQ_CH_REF = 2'h0;
   localparam logic [SSQ_CHAN_W-1:0] SSQ_CH_THERM = 2'h1;
   localparam logic [SSQ_CHAN_W-1:0] SSQ_CH_LIGHT = 2'h2;

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int SSQ_CLK_HZ = 40_000_000;
   localparam int SSQ_MS_PER_S = 1000;
   localparam int SSQ_CYC_PER_MS = SSQ_CLK_HZ / SSQ_MS_PER_S;

   // inter-pass delay per frequency code, in milliseconds
   localparam logic [SSQ_FREQ_W-1:0] SSQ_FREQ_SEC = 2'h0;
   localparam logic [SSQ_FREQ_W-1:0] SSQ_FREQ_HALF = 2'h1;
   localparam logic [SSQ_FREQ_W-1:0] SSQ_FREQ_TENTH = 2'h2;
   localparam logic [SSQ_FREQ_W-1:0] SSQ_FREQ_NONE = 2'h3;
   localparam logic [SSQ_MS_W-1:0] SSQ_DLY_SEC_MS = 16'h03E8;
   localparam logic [SSQ_MS_W-1:0] SSQ_DLY_HALF_MS = 16'h01F4;
   localparam logic [SSQ_MS_W-1:0] SSQ_DLY_TENTH_MS = 16'h0064;
   localparam logic [SSQ_MS_W-1:0] SSQ_DLY_NONE_MS = 16'h0000;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [SSQ_NUM_SENS-1:0] sensor_en;
      logic [SSQ_PASS_W-1:0] pass_count;
      logic [SSQ_FREQ_W-1:0] freq_sel;
   } ssq_cfg_type;

   typedef struct packed {
      logic req;
      logic [SSQ_CHAN_W-1:0] chan;
   } ssq_conv_req_type;

   typedef struct packed {
      logic done;
      logic [SSQ_DATA_W-1:0] data;
   } ssq_conv_rsp_type;

   typedef struct packed {
      logic found;
      logic [SSQ_CHAN_W-1:0] idx;
   } ssq_pick_type;

   typedef enum logic [3:0] {
      SSQ_ST_IDLE = 4'h1,
      SSQ_ST_REQ = 4'h2,
      SSQ_ST_WAIT = 4'h4,
      SSQ_ST_DELAY = 4'h8
   } ssq_state_type;

   function automatic logic [SSQ_MS_W-1:0] ssq_delay_ms(
      input logic [SSQ_FREQ_W-1:0] code);
      logic [SSQ_MS_W-1:0] ms;
      ms = SSQ_DLY_SEC_MS;
      unique case (code)
         SSQ_FREQ_SEC: ms = SSQ_DLY_SEC_MS;
         SSQ_FREQ_HALF: ms = SSQ_DLY_HALF_MS;
         SSQ_FREQ_TENTH: ms = SSQ_DLY_TENTH_MS;
         SSQ_FREQ_NONE: ms = SSQ_DLY_NONE_MS;
      endcase
      return ms;
   endfunction

endpackage

// >>> src/ssq_log_mem.sv
// Purpose: sample log memory, one write port, one registered read port
// Assumes: single clock, write and read may happen in the same cycle
// Notes: read data appear one cycle after the address
`timescale 1ns/1ps
module ssq_log_mem
   import ssq_pkg::*;
#(
   parameter int WIDTH = SSQ_DATA_W,
   parameter int DEPTH = 64,
   parameter int ADDR_W = $clog2(DEPTH)
)
(
   // clock
   input wire logic i_core_clk,
   // write side
   input wire logic i_wr_en,
   input wire logic [ADDR_W-1:0] i_wr_addr,
   input wire logic [WIDTH-1:0] i_wr_data,
   // read side
   input wire logic [ADDR_W-1:0] i_rd_addr,
   output logic [WIDTH-1:0] o_rd_data
);

   logic [WIDTH-1:0] mem_ff [DEPTH];

   if (DEPTH < 2)
   begin : g_chk
      $error("ssq_log_mem: DEPTH must be at least 2");
   end

   // no reset on the array so it maps to plain ram
   always_ff @(posedge i_core_clk)
   begin
      if (i_wr_en)
      begin
         mem_ff[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem_ff[i_rd_addr];
   end

endmodule

// >>> src/ssq_sequencer.sv
// Purpose: timed multi-pass sampling sequencer with a raw sample log
// Assumes: converter answers each request with one done pulse
// Notes: config is latched at start; start is ignored while busy
`timescale 1ns/1ps
module ssq_sequencer
   import ssq_pkg::*;
#(
   parameter int LOG_DEPTH = 64,
   parameter int MS_CYCLES = SSQ_CYC_PER_MS,
   parameter int ADDR_W = $clog2(LOG_DEPTH)
)
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // configuration and control
   input wire ssq_cfg_type i_cfg,
   input wire logic i_start,
   // status
   output logic o_busy,
   output logic o_data_avail,
   output logic o_overflow,
   output logic [ADDR_W:0] o_log_count,
   // converter channels
   output ssq_conv_req_type o_conv,
   input wire ssq_conv_rsp_type i_conv,
   // log read port
   input wire logic [ADDR_W-1:0] i_log_rd_addr,
   output logic [SSQ_DATA_W-1:0] o_log_rd_data
);

   localparam int CYC_W = $clog2(MS_CYCLES + 1);
   localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(MS_CYCLES - 1);
   localparam logic [ADDR_W:0] LOG_FULL = (ADDR_W+1)'(LOG_DEPTH);

   if (MS_CYCLES < 1 || LOG_DEPTH < 2 || (1 << ADDR_W) < LOG_DEPTH)
   begin : g_chk
      $error("ssq_sequencer: bad MS_CYCLES, LOG_DEPTH or ADDR_W");
   end

   // ----------------------------------------------------------------------
   // channel picking
   // ----------------------------------------------------------------------
   // lowest enabled channel at or above 'from'
   function automatic ssq_pick_type pick(
      input logic [SSQ_NUM_SENS-1:0] en,
      input logic [SSQ_CHAN_W:0] from);
      ssq_pick_type p;
      p = '0;
      for (int i = SSQ_NUM_SENS - 1; i >= 0; i--)
      begin
         if (en[i] && (i >= int'(from)))
         begin
            p.found = 1'b1;
            p.idx = SSQ_CHAN_W'(i);
         end
      end
      return p;
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   ssq_state_type state_ff, nxt_state;
   ssq_cfg_type cfg_ff, nxt_cfg;
   logic [SSQ_CHAN_W-1:0] chan_ff, nxt_chan;
   logic [SSQ_PASS_W-1:0] pass_left_ff, nxt_pass_left;
   logic [ADDR_W:0] addr_ff, nxt_addr;
   logic [SSQ_MS_W-1:0] ms_ff, nxt_ms;
   logic [CYC_W-1:0] cyc_ff, nxt_cyc;
   logic busy_ff, nxt_busy;
   logic avail_ff, nxt_avail;
   logic ovf_ff, nxt_ovf;
   logic wr_en;
   ssq_pick_type first_p, next_p, start_p;

   assign start_p = pick(i_cfg.sensor_en, '0);
   assign first_p = pick(cfg_ff.sensor_en, '0);
   assign next_p = pick(cfg_ff.sensor_en, {1'b0, chan_ff} + 1'b1);

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cfg = cfg_ff;
      nxt_chan = chan_ff;
      nxt_pass_left = pass_left_ff;
      nxt_addr = addr_ff;
      nxt_ms = ms_ff;
      nxt_cyc = cyc_ff;
      nxt_busy = busy_ff;
      nxt_avail = avail_ff;
      nxt_ovf = ovf_ff;
      wr_en = 1'b0;
      unique case (state_ff)
         SSQ_ST_IDLE:
         begin
            if (i_start)
            begin
               nxt_cfg = i_cfg;
               nxt_addr = '0;
               nxt_ovf = 1'b0;
               nxt_avail = 1'b0;
               nxt_pass_left = i_cfg.pass_count;
               // nothing to sample: finish at once
               if (i_cfg.pass_count == '0 || i_cfg.sensor_en == '0)
               begin
                  nxt_avail = 1'b1;
               end
               else
               begin
                  nxt_chan = start_p.idx;
                  nxt_busy = 1'b1;
                  nxt_state = SSQ_ST_REQ;
               end
            end
         end
         SSQ_ST_REQ:
         begin
            nxt_state = SSQ_ST_WAIT;
         end
         SSQ_ST_WAIT:
         begin
            if (i_conv.done)
            begin
               // log full: the sample is dropped but sequencing goes on
               if (addr_ff == LOG_FULL)
               begin
                  nxt_ovf = 1'b1;
               end
               else
               begin
                  wr_en = 1'b1;
                  nxt_addr = addr_ff + 1'b1;
               end
               if (next_p.found)
               begin
                  nxt_chan = next_p.idx;
                  nxt_state = SSQ_ST_REQ;
               end
               else if (pass_left_ff == 8'h01)
               begin
                  nxt_pass_left = '0;
                  nxt_busy = 1'b0;
                  nxt_avail = 1'b1;
                  nxt_state = SSQ_ST_IDLE;
               end
               else
               begin
                  nxt_pass_left = pass_left_ff - 1'b1;
                  nxt_ms = ssq_delay_ms(cfg_ff.freq_sel);
                  nxt_cyc = '0;
                  nxt_state = SSQ_ST_DELAY;
               end
            end
         end
         SSQ_ST_DELAY:
         begin
            if (ms_ff == '0)
            begin
               // channel moves only together with the request
               nxt_chan = first_p.idx;
               nxt_state = SSQ_ST_REQ;
            end
            else if (cyc_ff == CYC_LAST)
            begin
               nxt_cyc = '0;
               nxt_ms = ms_ff - 1'b1;
            end
            else
            begin
               nxt_cyc = cyc_ff + 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_ff <= SSQ_ST_IDLE;
         cfg_ff <= '0;
         chan_ff <= '0;
         pass_left_ff <= '0;
         addr_ff <= '0;
         ms_ff <= '0;
         cyc_ff <= '0;
         busy_ff <= 1'b0;
         avail_ff <= 1'b0;
         ovf_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cfg_ff <= nxt_cfg;
         chan_ff <= nxt_chan;
         pass_left_ff <= nxt_pass_left;
         addr_ff <= nxt_addr;
         ms_ff <= nxt_ms;
         cyc_ff <= nxt_cyc;
         busy_ff <= nxt_busy;
         avail_ff <= nxt_avail;
         ovf_ff <= nxt_ovf;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign o_conv.req = (state_ff == SSQ_ST_REQ);
   assign o_conv.chan = chan_ff;
   assign o_busy = busy_ff;
   assign o_data_avail = avail_ff;
   assign o_overflow = ovf_ff;
   assign o_log_count = addr_ff;

   // ----------------------------------------------------------------------
   // log memory
   // ----------------------------------------------------------------------
   // raw value only: the owner follows from order and count
   ssq_log_mem #(
      .WIDTH(SSQ_DATA_W),
      .DEPTH(LOG_DEPTH),
      .ADDR_W(ADDR_W)
   ) u_log (
      .i_core_clk(i_core_clk),
      .i_wr_en(wr_en),
      .i_wr_addr(addr_ff[ADDR_W-1:0]),
      .i_wr_data(i_conv.data),
      .i_rd_addr(i_log_rd_addr),
      .o_rd_data(o_log_rd_data)
   );

endmodule

// >>> bench/ssq_sequencer_props.sv
// Purpose: port checks of the sensor sampling sequencer
// Assumes: bound into every ssq_sequencer
// Notes: enable mask is latched here on each accepted start
`timescale 1ns/1ps
module ssq_sequencer_props
   import ssq_pkg::*;
#(
   parameter int LOG_DEPTH = 64,
   parameter int ADDR_W = $clog2(LOG_DEPTH)
)
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // control and status
   input wire ssq_cfg_type i_cfg,
   input wire logic i_start,
   input wire logic o_busy,
   input wire logic o_data_avail,
   input wire logic [ADDR_W:0] o_log_count,
   // converter
   input wire ssq_conv_req_type o_conv,
   input wire ssq_conv_rsp_type i_conv
);
   logic [SSQ_NUM_SENS-1:0] en_ff;
   logic [SSQ_NUM_SENS-1:0] nxt_en;
   logic go;
   logic nil;
   assign go = i_start && !o_busy;
   assign nil = (i_cfg.pass_count == 8'h00) || (i_cfg.sensor_en == 3'h0);
   always_comb nxt_en = go ? i_cfg.sensor_en : en_ff;
   always_ff @(posedge i_core_clk or negedge i_reset_n)
      if (!i_reset_n)
         en_ff <= 3'h0;
      else
         en_ff <= nxt_en;
   // -------------------------
   // properties
   // -------------------------
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   start_run_a:
      assert property (go && !nil |=> o_busy && o_conv.req && !o_data_avail)
      else $error("run did not start");
   empty_run_a:
      assert property (go && nil |=> !o_busy && o_data_avail)
      else $error("empty run not finished at once");
   req_pulse_a:
      assert property (o_conv.req |=> !o_conv.req)
      else $error("request longer than one cycle");
   req_busy_a:
      assert property (o_conv.req |-> o_busy)
      else $error("request while not busy");
   chan_enabled_a:
      assert property (o_conv.req |-> en_ff[o_conv.chan])
      else $error("disabled channel sampled");
   finish_avail_a:
      assert property ($fell(o_busy) |-> o_data_avail)
      else $error("no data available at finish");
   avail_hold_a:
      assert property (o_data_avail && !i_start |=> o_data_avail)
      else $error("data available dropped");
   log_step_a:
      assert property (o_busy && i_conv.done && !o_conv.req &&
         o_log_count < LOG_DEPTH |=> o_log_count == $past(o_log_count) + 1)
      else $error("log count did not step");
   chan_hold_a:
      assert property (!o_conv.req |-> $stable(o_conv.chan))
      else $error("channel moved without request");
endmodule
bind ssq_sequencer ssq_sequencer_props #(.LOG_DEPTH(LOG_DEPTH),
   .ADDR_W(ADDR_W)) i_ssq_sequencer_props (.i_core_clk(i_core_clk),
   .i_reset_n(i_reset_n), .i_cfg(i_cfg), .i_start(i_start),
   .o_busy(o_busy), .o_data_avail(o_data_avail),
   .o_log_count(o_log_count), .o_conv(o_conv), .i_conv(i_conv));

// >>> bench/ssq_conv_model.sv
// Purpose: converter channels answering each request once
// Assumes: latency of 1 to 4 cycles set by the bench
// Notes: sample values run up from a base, one per answer
`timescale 1ns/1ps
module ssq_conv_model
   import ssq_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // request side
   input wire ssq_conv_req_type i_conv,
   input wire logic [1:0] i_lat,
   input wire logic [SSQ_DATA_W-1:0] i_base,
   // answer side
   output ssq_conv_rsp_type o_rsp
);
   logic [2:0] cnt;
   logic [SSQ_DATA_W-1:0] num;
   always @(posedge i_core_clk or negedge i_reset_n)
      if (!i_reset_n)
      begin
         cnt <= 3'h0;
         num <= '0;
         o_rsp <= '0;
      end
      else
      begin
         o_rsp.done <= 1'b0;
         // data is invalid outside done, so a stale value never matches
         o_rsp.data <= ~o_rsp.data;
         if (cnt == 3'h1)
         begin
            o_rsp.done <= 1'b1;
            o_rsp.data <= i_base + num;
            num <= num + 16'h0001;
         end
         if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
         else if (i_conv.req)
            cnt <= {1'b0, i_lat} + 3'h1;
      end
endmodule

// >>> bench/test_ssq_sequencer.sv
// Purpose: self-checking bench of the sampling sequencer
// Assumes: one millisecond shortened to 4 cycles
// Notes: expected channel and gap notes are matched per request
`timescale 1ns/1ps
module test_ssq_sequencer
   import ssq_pkg::*;
;
   localparam int MSC = 4;
   localparam int LOGD = 64;
   localparam int DLY[4] = '{1000, 500, 100, 0};
   logic i_core_clk;
   logic i_reset_n;
   ssq_cfg_type i_cfg;
   logic i_start;
   logic o_busy;
   logic o_data_avail;
   logic o_overflow;
   logic [6:0] o_log_count;
   ssq_conv_req_type o_conv;
   ssq_conv_rsp_type i_conv;
   logic [5:0] i_log_rd_addr;
   logic [15:0] o_log_rd_data;
   logic [15:0] base;
   logic [31:0] r;
   logic [1:0] lat;
   logic rd;
   integer seed, err_total, cmp_count, cyc, t_ev, nsamp;
   logic [1:0] qc[$];
   int qg[$];
   logic [15:0] qd[$];
   ssq_sequencer #(.MS_CYCLES(MSC)) i_ssq_sequencer (
      .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_cfg(i_cfg),
      .i_start(i_start), .o_busy(o_busy), .o_data_avail(o_data_avail),
      .o_overflow(o_overflow), .o_log_count(o_log_count), .o_conv(o_conv),
      .i_conv(i_conv), .i_log_rd_addr(i_log_rd_addr),
      .o_log_rd_data(o_log_rd_data));
   ssq_conv_model i_ssq_conv_model (.i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n), .i_conv(o_conv), .i_lat(lat),
      .i_base(base), .o_rsp(i_conv));
   initial
   begin
      i_core_clk = 1'b0;
      forever #12.5 i_core_clk = ~i_core_clk;
   end
   task check(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask
   task stop_test;
      $display("mismatches %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // -------------------------
   // monitor
   // -------------------------
   always @(posedge i_core_clk)
   begin
      #1;
      cyc = cyc + 1;
      if (o_conv.req && qc.size() == 0)
         check("extra req", 1, 0);
      else if (o_conv.req)
      begin
         check("chan", o_conv.chan, qc.pop_front());
         check("gap", cyc - t_ev, qg.pop_front());
      end
      if (i_conv.done)
         t_ev = cyc;
      if (rd)
         check("log", o_log_rd_data, qd.pop_front());
   end
   task run(input logic [2:0] en, input logic [7:0] np, input logic [1:0] fs);
      int n, w, m;
      n = 0;
      for (int p = 0; p < np; p++)
      begin
         w = n;
         for (int c = 0; c < 3; c++)
            if (en[c])
            begin
               qc.push_back(2'(c));
               qg.push_back((p > 0 && n == w) ? 2 + DLY[fs] * MSC : 1);
               n++;
            end
      end
      @(negedge i_core_clk);
      i_cfg = '{en, np, fs};
      i_start = 1'b1;
      t_ev = cyc;
      @(negedge i_core_clk);
      // start held into the busy cycle must be ignored
      if (n > 0)
         i_cfg = 13'($random(seed));
      else
         i_start = 1'b0;
      if (n > 0)
      begin
         @(negedge i_core_clk);
         i_start = 1'b0;
      end
      w = 0;
      while (o_busy && w < 20000)
      begin
         @(negedge i_core_clk);
         w++;
      end
      m = (n > LOGD) ? LOGD : n;
      check("finish", w < 20000, 1);
      check("avail", o_data_avail, 1);
      check("count", o_log_count, m);
      check("ovf", o_overflow, n > LOGD);
      check("left", qc.size(), 0);
      for (int k = 0; k < m; k++)
      begin
         i_log_rd_addr = 6'(k);
         qd.push_back(base + 16'(nsamp + k));
         rd = 1'b1;
         @(negedge i_core_clk);
      end
      rd = 1'b0;
      nsamp += n;
   endtask
   initial
   begin
      seed = 32'hBCDB;
      err_total = 0;
      cmp_count = 0;
      cyc = 0;
      t_ev = 0;
      nsamp = 0;
      rd = 1'b0;
      i_cfg = '0;
      i_start = 1'b0;
      i_log_rd_addr = 6'h00;
      i_reset_n = 1'b0;
      lat = 2'h0;
      base = 16'($random(seed));
      repeat (5) @(negedge i_core_clk);
      i_reset_n = 1'b1;
      run(3'h7, 8'h04, SSQ_FREQ_SEC);
      run(3'h5, 8'h00, SSQ_FREQ_HALF);
      run(3'h0, 8'h03, SSQ_FREQ_TENTH);
      run(3'h7, 8'h16, SSQ_FREQ_NONE);
      for (int f = 0; f < 4; f++)
      begin
         r = $random(seed);
         lat = r[6:5];
         run(r[2:0] == 3'h0 ? 3'h6 : r[2:0], 8'h01 + r[4:3], 2'(f));
      end
      stop_test;
   end
   initial
   begin
      repeat (90000) @(posedge i_core_clk);
      err_total++;
      stop_test;
   end
endmodule
